// >>> logic/hcp_pkg.sv
package hcp_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned RST_RELEASE_US = 250;
    localparam int unsigned RST_RELEASE_CYC = RST_RELEASE_US * CLK_MHZ;
    localparam int RST_CNT_W = 17;
    localparam int SLP_CNT_W = 24;
    localparam int AXI_AW = 12;

    localparam logic [9:0] IDX_SLEEP_CONFIG_0 = 10'h211;
    localparam logic [9:0] IDX_INT_STATUS = 10'h212;
    localparam logic [9:0] IDX_INT_ENABLE = 10'h213;
    localparam logic [9:0] IDX_INT_MASK = 10'h214;
    localparam logic [9:0] IDX_WAKE_CTRL = 10'h215;
    localparam logic [9:0] IDX_SLEEP_INTERVAL = 10'h216;
    localparam logic [9:0] IDX_INACTIVE_PERIOD = 10'h217;
    localparam logic [9:0] IDX_GPIO_DIR = 10'h218;
    localparam logic [9:0] IDX_GPIO_DATA = 10'h219;
    localparam logic [9:0] IDX_GPIO_EXT = 10'h21A;
    localparam logic [9:0] IDX_SLEEP_COUNT = 10'h21B;

    localparam int CFG_CLK_SEL = 0;
    localparam int CFG_EDGE = 1;
    localparam int CFG_BEACON = 2;
    localparam int WK_EN = 0;
    localparam int WK_SLEEP = 1;
    localparam int ST_WAKE = 0;
    localparam int ST_INTERVAL = 1;
    localparam int ST_INACTIVE = 2;

    localparam logic [7:0] SLPCFG_RST = 8'h00;
    localparam logic [7:0] INT_EN_RST = 8'h00;
    localparam logic [7:0] INT_MASK_RST = 8'hFF;
    localparam logic [23:0] INTERVAL_RST = 24'h000100;
    localparam logic [23:0] INACTIVE_RST = 24'h000080;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        HCP_RST_HOLD = 3'b001,
        HCP_RST_DELAY = 3'b010,
        HCP_RST_RUN = 3'b100
    } hcp_rst_e;
endpackage

// >>> logic/hcp_sleep_cnt.sv
`timescale 1ns/100ps
module hcp_sleep_cnt (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dev_rst_i,
    input wire logic clk32_i,
    input wire logic clk100_i,
    input wire logic clk_sel_i,
    input wire logic beacon_i,
    input wire logic run_i,
    input wire logic [hcp_pkg::SLP_CNT_W-1:0] interval_i,
    input wire logic [hcp_pkg::SLP_CNT_W-1:0] inactive_i,
    output logic [hcp_pkg::SLP_CNT_W-1:0] count_o,
    output logic inactive_done_o,
    output logic interval_done_o
);
    typedef struct packed {
        logic p32;
        logic p100;
        logic [hcp_pkg::SLP_CNT_W-1:0] cnt;
        logic inact;
        logic done;
    } hcp_slp_s;

    hcp_slp_s q;
    hcp_slp_s next_q;
    logic tick;
    logic [hcp_pkg::SLP_CNT_W-1:0] cnt_inc;

    // pins are synchronous, so a rising edge of the chosen sleep clock is one tick
    assign tick = clk_sel_i ? (clk100_i & ~q.p100) : (clk32_i & ~q.p32);
    assign cnt_inc = q.cnt + 1'b1;

    always_comb begin
        next_q = q;
        next_q.p32 = clk32_i;
        next_q.p100 = clk100_i;
        next_q.inact = 1'b0;
        next_q.done = 1'b0;
        if (dev_rst_i || !run_i) begin
            next_q.cnt = '0;
        end else if (tick) begin
            // zero interval would never match, so it expires on every tick
            if (cnt_inc >= interval_i) begin
                next_q.done = 1'b1;
                next_q.cnt = '0;
            end else begin
                next_q.cnt = cnt_inc;
            end
            if (beacon_i && cnt_inc == inactive_i) begin
                next_q.inact = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign count_o = q.cnt;
    assign inactive_done_o = q.inact;
    assign interval_done_o = q.done;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_inact_beacon;
        inactive_done_o |-> $past(beacon_i) && $past(run_i);
    endproperty
    a_inact_beacon: assert property (p_inact_beacon) else $error("inactive event outside beacon mode");

    property p_done_at_interval;
        interval_done_o |-> ($past(q.cnt) + 1'b1 >= $past(interval_i)) && count_o == '0;
    endproperty
    a_done_at_interval: assert property (p_done_at_interval) else $error("interval ended at wrong count");

    property p_sel_clock;
        (run_i && !dev_rst_i && clk_sel_i && !clk100_i) |=> count_o == $past(count_o) || !$past(run_i);
    endproperty
    a_sel_clock: assert property (p_sel_clock) else $error("count moved without selected clock edge");

    c_interval: cover property (interval_done_o);
endmodule

// >>> logic/hcp_top.sv
`timescale 1ns/100ps
module hcp_top #(
    parameter int unsigned RELEASE_CYCLES = hcp_pkg::RST_RELEASE_CYC
) (
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic [hcp_pkg::AXI_AW-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [hcp_pkg::AXI_AW-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic RESET_N_I,
    input wire logic WAKE_I,
    output logic INT_O,
    input wire logic SLEEP_CLK32_I,
    input wire logic SLEEP_CLK100_I,
    input wire logic [3:0] EVT_I,
    input wire logic TX_ACTIVE_I,
    input wire logic RX_ACTIVE_I,
    input wire logic [5:0] GPIO_I,
    output logic [5:0] GPIO_O,
    output logic [5:0] GPIO_OE_O,
    output logic DEVICE_RST_O,
    output logic MAIN_CLK_EN_O
);
    typedef struct packed {
        hcp_pkg::hcp_rst_e rst_st;
        logic [hcp_pkg::RST_CNT_W-1:0] rst_cnt;
        logic [7:0] slpcfg;
        logic [7:0] stat;
        logic [7:0] int_en;
        logic [7:0] int_mask;
        logic wake_en;
        logic sleeping;
        logic wake_prev;
        logic [23:0] interval;
        logic [23:0] inactive;
        logic [5:0] gpio_dir;
        logic [5:0] gpio_dat;
        logic gpio_ext;
        logic [5:0] gpio_o;
        logic [5:0] gpio_oe;
        logic aw_got;
        logic [9:0] aw_idx;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } hcp_top_s;

    hcp_top_s q;
    hcp_top_s next_q;
    logic dev_rst;
    logic irq;
    logic wake_hit;
    logic wr_do;
    logic rd_take;
    logic [9:0] ar_idx;
    logic [23:0] slp_count;
    logic slp_inact;
    logic slp_done;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [31:0] wr_val;
    logic [31:0] rd_val;
    logic rd_ok;
    logic wr_ok;

    localparam logic [hcp_pkg::RST_CNT_W-1:0] REL_LAST = hcp_pkg::RST_CNT_W'(RELEASE_CYCLES - 1);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign dev_rst = q.rst_st != hcp_pkg::HCP_RST_RUN;
    assign irq = |(q.stat & q.int_en & ~q.int_mask);
    assign wake_hit = WAKE_I & ~q.wake_prev & q.wake_en & q.sleeping;
    assign wr_do = q.aw_got && q.w_got && !q.bvalid;
    assign rd_take = S_AXI_ARVALID_I && !q.rvalid;
    assign ar_idx = S_AXI_ARADDR_I[11:2];
    assign set_vec = {EVT_I, 1'b0, slp_inact, slp_done, wake_hit};

    hcp_sleep_cnt u_sleep (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .dev_rst_i(dev_rst),
        .clk32_i(SLEEP_CLK32_I),
        .clk100_i(SLEEP_CLK100_I),
        .clk_sel_i(q.slpcfg[hcp_pkg::CFG_CLK_SEL]),
        .beacon_i(q.slpcfg[hcp_pkg::CFG_BEACON]),
        .run_i(q.sleeping || q.slpcfg[hcp_pkg::CFG_BEACON]),
        .interval_i(q.interval),
        .inactive_i(q.inactive),
        .count_o(slp_count),
        .inactive_done_o(slp_inact),
        .interval_done_o(slp_done)
    );

    always_comb begin
        rd_ok = 1'b1;
        rd_val = '0;
        unique case (ar_idx)
            hcp_pkg::IDX_SLEEP_CONFIG_0: rd_val[7:0] = q.slpcfg;
            hcp_pkg::IDX_INT_STATUS: rd_val[7:0] = q.stat;
            hcp_pkg::IDX_INT_ENABLE: rd_val[7:0] = q.int_en;
            hcp_pkg::IDX_INT_MASK: rd_val[7:0] = q.int_mask;
            hcp_pkg::IDX_WAKE_CTRL: rd_val[1:0] = {q.sleeping, q.wake_en};
            hcp_pkg::IDX_SLEEP_INTERVAL: rd_val[23:0] = q.interval;
            hcp_pkg::IDX_INACTIVE_PERIOD: rd_val[23:0] = q.inactive;
            hcp_pkg::IDX_GPIO_DIR: rd_val[5:0] = q.gpio_dir;
            hcp_pkg::IDX_GPIO_DATA: rd_val[5:0] = GPIO_I;
            hcp_pkg::IDX_GPIO_EXT: rd_val[0] = q.gpio_ext;
            hcp_pkg::IDX_SLEEP_COUNT: rd_val[23:0] = slp_count;
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb begin
        next_q = q;
        wr_ok = 1'b1;
        wr_val = '0;
        clr_vec = '0;
        next_q.wake_prev = WAKE_I;

        unique case (q.rst_st)
            hcp_pkg::HCP_RST_HOLD: begin
                next_q.rst_cnt = '0;
                if (RESET_N_I) begin
                    next_q.rst_st = hcp_pkg::HCP_RST_DELAY;
                end
            end
            hcp_pkg::HCP_RST_DELAY: begin
                if (!RESET_N_I) begin
                    next_q.rst_st = hcp_pkg::HCP_RST_HOLD;
                    next_q.rst_cnt = '0;
                end else if (q.rst_cnt == REL_LAST) begin
                    next_q.rst_st = hcp_pkg::HCP_RST_RUN;
                end else begin
                    next_q.rst_cnt = q.rst_cnt + 1'b1;
                end
            end
            hcp_pkg::HCP_RST_RUN: begin
                if (!RESET_N_I) begin
                    next_q.rst_st = hcp_pkg::HCP_RST_HOLD;
                end
            end
        endcase

        if (wr_do) begin
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.bvalid = 1'b1;
            unique case (q.aw_idx)
                hcp_pkg::IDX_SLEEP_CONFIG_0: wr_val[7:0] = q.slpcfg;
                hcp_pkg::IDX_INT_ENABLE: wr_val[7:0] = q.int_en;
                hcp_pkg::IDX_INT_MASK: wr_val[7:0] = q.int_mask;
                hcp_pkg::IDX_SLEEP_INTERVAL: wr_val[23:0] = q.interval;
                hcp_pkg::IDX_INACTIVE_PERIOD: wr_val[23:0] = q.inactive;
                hcp_pkg::IDX_GPIO_DIR: wr_val[5:0] = q.gpio_dir;
                hcp_pkg::IDX_GPIO_DATA: wr_val[5:0] = q.gpio_dat;
                hcp_pkg::IDX_GPIO_EXT: wr_val[0] = q.gpio_ext;
                hcp_pkg::IDX_INT_STATUS, hcp_pkg::IDX_WAKE_CTRL, hcp_pkg::IDX_SLEEP_COUNT: wr_val = '0;
                default: wr_ok = 1'b0;
            endcase
            wr_val = merge(wr_val, q.wdata, q.wstrb);
            next_q.bresp = wr_ok ? hcp_pkg::RESP_OKAY : hcp_pkg::RESP_SLVERR;
            if (!dev_rst) begin
                unique case (q.aw_idx)
                    hcp_pkg::IDX_SLEEP_CONFIG_0: next_q.slpcfg = wr_val[7:0];
                    hcp_pkg::IDX_INT_STATUS: clr_vec = wr_val[7:0];
                    hcp_pkg::IDX_INT_ENABLE: next_q.int_en = wr_val[7:0];
                    hcp_pkg::IDX_INT_MASK: next_q.int_mask = wr_val[7:0];
                    hcp_pkg::IDX_WAKE_CTRL: begin
                        next_q.wake_en = wr_val[hcp_pkg::WK_EN];
                        if (wr_val[hcp_pkg::WK_SLEEP]) begin
                            next_q.sleeping = 1'b1;
                        end
                    end
                    hcp_pkg::IDX_SLEEP_INTERVAL: next_q.interval = wr_val[23:0];
                    hcp_pkg::IDX_INACTIVE_PERIOD: next_q.inactive = wr_val[23:0];
                    hcp_pkg::IDX_GPIO_DIR: next_q.gpio_dir = wr_val[5:0];
                    hcp_pkg::IDX_GPIO_DATA: next_q.gpio_dat = wr_val[5:0];
                    hcp_pkg::IDX_GPIO_EXT: next_q.gpio_ext = wr_val[0];
                    default: ;
                endcase
            end
        end else begin
            if (S_AXI_AWVALID_I && !q.aw_got) begin
                next_q.aw_got = 1'b1;
                next_q.aw_idx = S_AXI_AWADDR_I[11:2];
            end
            if (S_AXI_WVALID_I && !q.w_got) begin
                next_q.w_got = 1'b1;
                next_q.wdata = S_AXI_WDATA_I;
                next_q.wstrb = S_AXI_WSTRB_I;
            end
        end
        if (q.bvalid && S_AXI_BREADY_I) begin
            next_q.bvalid = 1'b0;
        end

        if (rd_take) begin
            next_q.rvalid = 1'b1;
            next_q.rdata = rd_val;
            next_q.rresp = rd_ok ? hcp_pkg::RESP_OKAY : hcp_pkg::RESP_SLVERR;
            // reading status clears all of its bits and releases the interrupt line; a write to it clears only the bits written as 1
            if (ar_idx == hcp_pkg::IDX_INT_STATUS) begin
                clr_vec = 8'hFF;
            end
        end else if (q.rvalid && S_AXI_RREADY_I) begin
            next_q.rvalid = 1'b0;
        end

        // an event in the clearing cycle is kept: set wins
        next_q.stat = (q.stat & ~clr_vec) | set_vec;
        if (wake_hit || (slp_done && !q.slpcfg[hcp_pkg::CFG_BEACON])) begin
            next_q.sleeping = 1'b0;
        end

        if (q.gpio_ext) begin
            next_q.gpio_o = {q.gpio_dat[5:3], RX_ACTIVE_I, TX_ACTIVE_I, TX_ACTIVE_I};
            next_q.gpio_oe = {q.gpio_dir[5:3], 3'h7};
        end else begin
            next_q.gpio_o = q.gpio_dat;
            next_q.gpio_oe = q.gpio_dir;
        end

        if (dev_rst) begin
            next_q.slpcfg = hcp_pkg::SLPCFG_RST;
            next_q.stat = '0;
            next_q.int_en = hcp_pkg::INT_EN_RST;
            next_q.int_mask = hcp_pkg::INT_MASK_RST;
            next_q.wake_en = 1'b0;
            next_q.sleeping = 1'b0;
            next_q.interval = hcp_pkg::INTERVAL_RST;
            next_q.inactive = hcp_pkg::INACTIVE_RST;
            next_q.gpio_dir = '0;
            next_q.gpio_dat = '0;
            next_q.gpio_ext = 1'b0;
            next_q.gpio_o = '0;
            next_q.gpio_oe = '0;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            q <= '{rst_st: hcp_pkg::HCP_RST_HOLD, slpcfg: hcp_pkg::SLPCFG_RST, int_en: hcp_pkg::INT_EN_RST,
                   int_mask: hcp_pkg::INT_MASK_RST, interval: hcp_pkg::INTERVAL_RST,
                   inactive: hcp_pkg::INACTIVE_RST, default: '0};
        end else begin
            q <= next_q;
        end
    end

    assign INT_O = q.slpcfg[hcp_pkg::CFG_EDGE] ? irq : ~irq;
    assign DEVICE_RST_O = dev_rst;
    // main clock is gated off while held in reset or asleep
    assign MAIN_CLK_EN_O = !dev_rst && !q.sleeping;
    assign GPIO_O = q.gpio_o;
    assign GPIO_OE_O = q.gpio_oe;
    assign S_AXI_AWREADY_O = !q.aw_got;
    assign S_AXI_WREADY_O = !q.w_got;
    assign S_AXI_BVALID_O = q.bvalid;
    assign S_AXI_BRESP_O = q.bresp;
    assign S_AXI_ARREADY_O = !q.rvalid;
    assign S_AXI_RVALID_O = q.rvalid;
    assign S_AXI_RDATA_O = q.rdata;
    assign S_AXI_RRESP_O = q.rresp;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (SYS_RST_I);

    property p_enter_reset;
        !RESET_N_I |=> DEVICE_RST_O && !MAIN_CLK_EN_O;
    endproperty
    a_enter_reset: assert property (p_enter_reset) else $error("reset pin low did not reset device");

    property p_release_delay;
        $fell(DEVICE_RST_O) |-> $past(q.rst_cnt) == REL_LAST && $past(RESET_N_I);
    endproperty
    a_release_delay: assert property (p_release_delay) else $error("reset released at wrong time");

    property p_restart;
        (q.rst_st == hcp_pkg::HCP_RST_DELAY && !RESET_N_I) |=> q.rst_cnt == '0 ##1 q.rst_cnt == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("release delay not restarted");

    property p_polarity;
        (q.slpcfg[hcp_pkg::CFG_EDGE] != $past(q.slpcfg[hcp_pkg::CFG_EDGE])) |-> INT_O != $past(INT_O);
    endproperty
    a_polarity: assert property (p_polarity) else $error("edge select did not flip interrupt level");

    property p_reset_default;
        $fell(DEVICE_RST_O) |-> !q.slpcfg[hcp_pkg::CFG_EDGE] && INT_O;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("interrupt not idle high after reset");

    property p_gated;
        !(|(q.int_en & ~q.int_mask)) |-> INT_O != q.slpcfg[hcp_pkg::CFG_EDGE];
    endproperty
    a_gated: assert property (p_gated) else $error("interrupt active while disabled or masked");

    property p_hold;
        (irq && !rd_take && !wr_do && RESET_N_I && !dev_rst) |=> irq;
    endproperty
    a_hold: assert property (p_hold) else $error("interrupt dropped without status read");

    property p_wake_ignored;
        (q.sleeping && !q.wake_en && !slp_done && RESET_N_I && !dev_rst) |=> q.sleeping;
    endproperty
    a_wake_ignored: assert property (p_wake_ignored) else $error("wake acted while disabled");

    property p_wake_ends_sleep;
        (wake_hit && RESET_N_I) |=> !q.sleeping && MAIN_CLK_EN_O && q.stat[hcp_pkg::ST_WAKE];
    endproperty
    a_wake_ends_sleep: assert property (p_wake_ends_sleep) else $error("wake did not end sleep");

    property p_pa_enable;
        (q.gpio_ext && !dev_rst && RESET_N_I) |=> GPIO_O[0] == $past(TX_ACTIVE_I) && GPIO_OE_O[2:0] == 3'h7;
    endproperty
    a_pa_enable: assert property (p_pa_enable) else $error("pa enable not following transmit");

    property p_main_clk;
        MAIN_CLK_EN_O |-> !DEVICE_RST_O && !q.sleeping;
    endproperty
    a_main_clk: assert property (p_main_clk) else $error("main clock enabled in reset or sleep");

    c_release: cover property ($fell(DEVICE_RST_O));
    c_irq_read: cover property (irq ##[1:20] (rd_take && ar_idx == hcp_pkg::IDX_INT_STATUS));
    c_wake: cover property (wake_hit);
endmodule

// >>> tb/hcp_host_model.sv
`timescale 1ns/100ps
module hcp_host_model (
    input wire logic clk_i,
    input wire logic int_i,
    input wire logic edge_i,
    output logic reset_n_o,
    output logic wake_o,
    output logic irq_o
);
    // host input polarity tracks the edge setting it last wrote
    assign irq_o = edge_i ? int_i : !int_i;
    initial begin
        reset_n_o = 1'b0;
        wake_o = 1'b0;
    end
    task automatic set_rst(input logic v);
        @(posedge clk_i);
        reset_n_o <= v;
    endtask
    // held two cycles so a synchronous edge detector cannot miss it
    task automatic wake_pulse();
        @(posedge clk_i);
        wake_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        wake_o <= 1'b0;
    endtask
endmodule

// >>> tb/tb_host_control_pins.sv
`timescale 1ns/100ps
module tb_host_control_pins;
    localparam int REL = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awa = '0;
    logic [11:0] ara = '0;
    logic [31:0] wd = '0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [3:0] evt = '0;
    logic [1:0] slk = '0;
    logic tx = 1'b0, rx = 1'b0, edge_sel = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic [5:0] gpi = '0;
    logic awr, wrdy, bv, arr, rv, intr, rstn, wake, irq, dev_rst, clk_en;
    logic [1:0] br, rr;
    logic [31:0] rdat;
    logic [5:0] gpo, gpoe;
    int err_total = 0;
    int check_count = 0;

    hcp_top #(.RELEASE_CYCLES(REL)) u_dut (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
        .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .RESET_N_I(rstn),
        .WAKE_I(wake), .INT_O(intr), .SLEEP_CLK32_I(slk[0]), .SLEEP_CLK100_I(slk[1]), .EVT_I(evt),
        .TX_ACTIVE_I(tx), .RX_ACTIVE_I(rx), .GPIO_I(gpi), .GPIO_O(gpo), .GPIO_OE_O(gpoe),
        .DEVICE_RST_O(dev_rst), .MAIN_CLK_EN_O(clk_en)
    );
    hcp_host_model u_host (
        .clk_i(clk), .int_i(intr), .edge_i(edge_sel), .reset_n_o(rstn), .wake_o(wake), .irq_o(irq)
    );

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic summarize();
        $display("errors=%0d checks=%0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er = hcp_pkg::RESP_OKAY,
                      input logic [3:0] st = 4'hF);
        logic a, w;
        a = 1'b1;
        w = 1'b1;
        @(posedge clk);
        awa <= {idx, 2'b00};
        wd <= d;
        wstrb <= st;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (a || w) begin
            @(posedge clk);
            if (a && awr) begin
                a = 1'b0;
                awv <= 1'b0;
            end
            if (w && wrdy) begin
                w = 1'b0;
                wv <= 1'b0;
            end
        end
        while (!bv) @(posedge clk);
        chk(32'(br), 32'(er));
        bry <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er = hcp_pkg::RESP_OKAY);
        @(posedge clk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        chk(rdat, ed);
        chk(32'(rr), 32'(er));
        rry <= 1'b0;
    endtask
    // release lands exactly REL+1 edges after the pin is driven high
    task automatic rel_chk();
        u_host.set_rst(1'b1);
        repeat (REL) @(posedge clk);
        #1 chk(32'(dev_rst), 32'h1);
        @(posedge clk);
        #1 chk(32'(dev_rst), 32'h0);
    endtask
    task automatic ev();
        @(posedge clk);
        evt <= 4'h1;
        @(posedge clk);
        evt <= 4'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic tick(input logic s, input int n);
        repeat (n) begin
            @(posedge clk);
            slk[s] <= 1'b1;
            repeat (4) @(posedge clk);
            slk[s] <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rel_chk();
        u_host.set_rst(1'b0);
        u_host.set_rst(1'b1);
        repeat (4) @(posedge clk);
        u_host.set_rst(1'b0);
        rel_chk();
        rd(hcp_pkg::IDX_SLEEP_CONFIG_0, 32'h0);
        rd(hcp_pkg::IDX_INT_MASK, 32'hFF);
        #1 chk(32'(intr), 32'h1);
        ev();
        #1 chk(32'(intr), 32'h1);
        wr(hcp_pkg::IDX_INT_ENABLE, 32'h10);
        #1 chk(32'(intr), 32'h1);
        wr(hcp_pkg::IDX_INT_MASK, 32'hEF);
        #1 chk(32'(irq), 32'h1);
        repeat (6) @(posedge clk);
        #1 chk(32'(intr), 32'h0);
        rd(hcp_pkg::IDX_INT_STATUS, 32'h10);
        #1 chk(32'(intr), 32'h1);
        wr(hcp_pkg::IDX_SLEEP_CONFIG_0, 32'h2);
        edge_sel <= 1'b1;
        #1 chk(32'(intr), 32'h0);
        ev();
        #1 chk(32'(irq), 32'h1);
        wr(hcp_pkg::IDX_INT_STATUS, 32'h10);
        #1 chk(32'(intr), 32'h0);
        u_host.set_rst(1'b0);
        @(posedge clk);
        #1 chk(32'(dev_rst), 32'h1);
        rel_chk();
        rd(hcp_pkg::IDX_SLEEP_CONFIG_0, 32'h0);
        edge_sel <= 1'b0;
        wr(hcp_pkg::IDX_WAKE_CTRL, 32'h2);
        #1 chk(32'(clk_en), 32'h0);
        u_host.wake_pulse();
        rd(hcp_pkg::IDX_WAKE_CTRL, 32'h2);
        wr(hcp_pkg::IDX_WAKE_CTRL, 32'h3);
        u_host.wake_pulse();
        rd(hcp_pkg::IDX_WAKE_CTRL, 32'h1);
        #1 chk(32'(clk_en), 32'h1);
        rd(hcp_pkg::IDX_INT_STATUS, 32'h1);
        for (int s = 0; s < 2; s++) begin
            wr(hcp_pkg::IDX_SLEEP_INTERVAL, 32'h3);
            wr(hcp_pkg::IDX_SLEEP_CONFIG_0, 32'(s));
            wr(hcp_pkg::IDX_WAKE_CTRL, 32'h3);
            tick(!s[0], 6);
            rd(hcp_pkg::IDX_WAKE_CTRL, 32'h3);
            tick(s[0], 6);
            rd(hcp_pkg::IDX_WAKE_CTRL, 32'h1);
            rd(hcp_pkg::IDX_INT_STATUS, 32'h2);
        end
        // beacon mode: counter runs without sleep, inactive period flagged before the interval
        wr(hcp_pkg::IDX_INACTIVE_PERIOD, 32'h2);
        wr(hcp_pkg::IDX_SLEEP_INTERVAL, 32'h3);
        wr(hcp_pkg::IDX_SLEEP_CONFIG_0, 32'h4);
        tick(1'b0, 3);
        rd(hcp_pkg::IDX_INT_STATUS, 32'h6);
        rd(hcp_pkg::IDX_WAKE_CTRL, 32'h1);
        wr(hcp_pkg::IDX_SLEEP_INTERVAL, 32'h00AABB77, hcp_pkg::RESP_OKAY, 4'h2);
        rd(hcp_pkg::IDX_SLEEP_INTERVAL, 32'h0000BB03);
        tick(1'b0, 2);
        rd(hcp_pkg::IDX_SLEEP_COUNT, 32'h2);
        wr(hcp_pkg::IDX_GPIO_EXT, 32'h1);
        tx <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(32'({gpoe[2:0], gpo[2:0]}), 32'h3B);
        @(posedge clk);
        tx <= 1'b0;
        rx <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(32'({gpoe[2:0], gpo[2:0]}), 32'h3C);
        wr(hcp_pkg::IDX_GPIO_EXT, 32'h0);
        wr(hcp_pkg::IDX_GPIO_DIR, 32'h3F);
        wr(hcp_pkg::IDX_GPIO_DATA, 32'h15);
        gpi <= 6'h2A;
        repeat (2) @(posedge clk);
        #1 chk(32'({gpoe, gpo}), 32'hFD5);
        rd(hcp_pkg::IDX_GPIO_DATA, 32'h2A);
        rd(10'h000, 32'h0, hcp_pkg::RESP_SLVERR);
        wr(10'h000, 32'h1, hcp_pkg::RESP_SLVERR);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
